// ==== core/iecl_core.sv ====
// Interrupt entry, return and wait/stop sequencer with APB option register
//
// Operation
// (RQ1) Three flag sets: main, maskable, nonmaskable
// (RQ2) Entry swaps carry/zero to service flag set
// (RQ3) Entry pushes program counter onto stack
// (RQ4) Service blocks maskable requests, nonmaskable still live
// (RQ5) Entry clears accepted source's first latch
// (RQ6) Entry ends loading the source's vector
// (RQ7) Return restores prior flags and pops counter
// (RQ8) Global enable gates all but nonmaskable
// (RQ9) Wait halts core, clock keeps running
// (RQ10) Wake from wait has no delay
// (RQ11) Stop only without watchdog, stops oscillator
// (RQ12) Wake from stop waits for oscillator
// (RQ13) Reset during wait runs normal reset
// (RQ14) Main-program wake services interrupt, then continues
// (RQ15) Nonmaskable-context wake only resumes, no service
// (RQ16) Maskable wake in routine continues that routine
// (RQ17) Nonmaskable wake in routine services nonmaskable first
// (RQ18) Wake leaves oscillator selection untouched
// (RQ19) Watchdog active turns stop into wait
// (RQ20) Enable low: only reset wakes
// (RQ21) No wait or stop with request pending
// (RQ22) Write-only option register clears on reset
// (RQ23) Fixed priority, one highest, no nesting
// (RQ24) Skipped sleep goes to entry next boundary
`timescale 1ns/100ps
`default_nettype none
module iecl_core
    import iecl_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_CYCLES_DEFAULT,
    parameter int STACK_DEPTH = STACK_DEPTH_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        instr_boundary,
    input  wire logic        exec_wait,
    input  wire logic        exec_stop,
    input  wire logic        exec_return,
    input  wire logic [11:0] pc_current,
    input  wire logic        flag_we,
    input  wire logic        flag_c_in,
    input  wire logic        flag_z_in,
    input  wire logic        wdg_active,
    input  wire logic        nmi_req,
    input  wire logic [3:0]  irq_req,
    output var  logic        flag_c,
    output var  logic        flag_z,
    output var  logic        pc_load,
    output var  logic [11:0] pc_value,
    output var  logic [4:0]  latch_clr,
    output var  logic        core_halt,
    output var  logic        osc_stop,
    output var  logic [1:0]  service_ctx,
    output var  logic        level_mode_a,
    output var  logic        rise_mode_bc
);
    localparam int SPW = $clog2(STACK_DEPTH + 1);

    iecl_if      arb_bus ();
    iecl_state_e state;
    iecl_ctx_e   ctx;
    iecl_ctx_e   nmi_prev;
    logic [7:0]  int_option;
    logic [1:0]  bank_c;
    logic [1:0]  bank_z;
    logic [11:0] pc_stack [STACK_DEPTH];
    logic [SPW-1:0] sp;
    logic [15:0] stab_cnt;
    logic        gen;
    logic        do_return;
    logic        do_sleep;
    logic        do_entry;
    logic        sleep_stop;
    logic        setup;
    logic        access;
    logic        hit_option;
    logic        hit_status;
    logic [11:0] vec;

    assign gen = int_option[BIT_GEN];

    iecl_arbiter u_arb (
        .bus (arb_bus)
    );

    assign arb_bus.req = irq_req;
    assign arb_bus.nmi = nmi_req;
    assign arb_bus.gen = gen;
    assign arb_bus.ctx = ctx;

    // Sequencing decisions, all at an instruction boundary while running
    assign do_return  = (state == ST_RUN) && instr_boundary && exec_return
                        && (ctx != CTX_MAIN);
    // A pending enabled request cancels the sleep; the next boundary enters unless the current context blocks that request
    assign do_sleep   = (state == ST_RUN) && instr_boundary
                        && (exec_wait || exec_stop) && !arb_bus.pending;    // [RQ21] [RQ24]
    assign do_entry   = (state == ST_RUN) && instr_boundary
                        && !exec_return && !exec_wait && !exec_stop
                        && (arb_bus.take_nmi || arb_bus.take_irq);          // [RQ24]
    // Stop is only honoured with the watchdog off
    assign sleep_stop = exec_stop && !wdg_active;                           // [RQ11] [RQ19]

    always_comb begin
        case (arb_bus.irq_sel)
            2'd0:    vec = VEC_1;
            2'd1:    vec = VEC_2;
            2'd2:    vec = VEC_3;
            default: vec = VEC_4;
        endcase
    end

    // APB slave: one wait-free access phase, answer prepared at setup
    assign setup      = psel && !penable;
    assign access     = psel && penable && pready;
    assign hit_option = (paddr[11:2] == ADDR_INT_OPTION[11:2]);
    assign hit_status = (paddr[11:2] == ADDR_STATUS[11:2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !(hit_option || (hit_status && !pwrite));
            // Option register is write-only and reads as zero
            if (!pwrite && hit_status) begin
                prdata <= {24'h00_0000, 4'(sp), 2'(state), 2'(ctx)};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    // Cleared at reset, so every maskable source starts disabled; the nonmaskable one is still taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_option <= INT_OPTION_RESET;                                 // [RQ22]
        end else if (access && pwrite && hit_option) begin
            int_option <= pwdata[7:0];                                      // [RQ8] [RQ22]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_mode_a <= 1'b0;
            rise_mode_bc <= 1'b0;
        end else begin
            level_mode_a <= int_option[BIT_LES];
            rise_mode_bc <= int_option[BIT_ESB];
        end
    end

    // Power state; async reset always lands in run, abandoning any sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;                                                // [RQ13]
        end else begin
            case (state)
                ST_RUN: begin
                    if (do_sleep) begin
                        state <= sleep_stop ? ST_STOP : ST_WAIT;            // [RQ9] [RQ11] [RQ19]
                    end
                end
                ST_WAIT: begin
                    // Clock never stopped, so no settling time
                    if (arb_bus.wake) begin
                        state <= ST_RUN;                                    // [RQ10] [RQ20]
                    end
                end
                ST_STOP: begin
                    if (arb_bus.wake) begin
                        state <= ST_STAB;                                   // [RQ12] [RQ20]
                    end
                end
                ST_STAB: begin
                    if (stab_cnt == 16'(STAB_CYCLES - 1)) begin
                        state <= ST_RUN;                                    // [RQ12]
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stab_cnt <= 16'h0000;
        end else if (state == ST_STAB) begin
            stab_cnt <= stab_cnt + 16'h0001;                                // [RQ12]
        end else begin
            stab_cnt <= 16'h0000;
        end
    end

    // Oscillator select lives elsewhere; only the stop request is driven here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_halt <= 1'b0;
            osc_stop  <= 1'b0;
        end else begin
            case (state)
                ST_RUN: begin
                    core_halt <= do_sleep;                                  // [RQ9]
                    osc_stop  <= do_sleep && sleep_stop;                    // [RQ11] [RQ18]
                end
                ST_WAIT: begin
                    core_halt <= !arb_bus.wake;                             // [RQ10]
                    osc_stop  <= 1'b0;
                end
                ST_STOP: begin
                    core_halt <= 1'b1;
                    osc_stop  <= !arb_bus.wake;                             // [RQ11]
                end
                ST_STAB: begin
                    core_halt <= (stab_cnt != 16'(STAB_CYCLES - 1));        // [RQ12]
                    osc_stop  <= 1'b0;
                end
                default: begin
                    core_halt <= 1'b0;
                    osc_stop  <= 1'b0;
                end
            endcase
        end
    end

    // Context tracking; arbiter decides resume after wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctx      <= CTX_MAIN;
            nmi_prev <= CTX_MAIN;
        end else if (do_entry && arb_bus.take_nmi) begin
            ctx      <= CTX_NMI;                                            // [RQ15] [RQ17]
            nmi_prev <= ctx;                                                // [RQ17]
        end else if (do_entry) begin
            ctx      <= CTX_IRQ;                                            // [RQ4] [RQ14] [RQ16]
        end else if (do_return) begin
            ctx      <= (ctx == CTX_NMI) ? nmi_prev : CTX_MAIN;             // [RQ7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            service_ctx <= 2'b00;
        end else begin
            service_ctx <= 2'(ctx);
        end
    end

    // Active flags sit in the outputs; the bank keeps only the interrupted main and maskable sets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_c <= 1'b0;
            flag_z <= 1'b0;
            bank_c <= 2'b00;
            bank_z <= 2'b00;
        end else if (do_entry) begin
            if (ctx == CTX_MAIN) begin
                bank_c[0] <= flag_c;                                        // [RQ1]
                bank_z[0] <= flag_z;
            end else begin
                bank_c[1] <= flag_c;
                bank_z[1] <= flag_z;
            end
            // Service routines always start on a fresh set
            flag_c <= 1'b0;                                                 // [RQ2]
            flag_z <= 1'b0;                                                 // [RQ2]
        end else if (do_return) begin
            if ((ctx == CTX_NMI) && (nmi_prev == CTX_IRQ)) begin
                flag_c <= bank_c[1];                                        // [RQ7]
                flag_z <= bank_z[1];
            end else begin
                flag_c <= bank_c[0];                                        // [RQ7]
                flag_z <= bank_z[0];
            end
        end else if (flag_we) begin
            flag_c <= flag_c_in;                                            // [RQ1]
            flag_z <= flag_z_in;
        end
    end

    // Return stack: shifts down on push, oldest level lost on overflow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                pc_stack[i] <= 12'h000;
            end
            sp <= '0;
        end else if (do_entry) begin
            pc_stack[0] <= pc_current;                                      // [RQ3]
            for (int i = 1; i < STACK_DEPTH; i++) begin
                pc_stack[i] <= pc_stack[i-1];
            end
            if (sp != SPW'(STACK_DEPTH)) begin
                sp <= sp + SPW'(1);
            end
        end else if (do_return) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                pc_stack[i] <= pc_stack[i+1];                               // [RQ7]
            end
            pc_stack[STACK_DEPTH-1] <= 12'h000;
            if (sp != '0) begin
                sp <= sp - SPW'(1);
            end
        end
    end

    // Counter load: vector on entry, popped address on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load  <= 1'b0;
            pc_value <= 12'h000;
        end else if (do_entry) begin
            pc_load  <= 1'b1;
            pc_value <= arb_bus.take_nmi ? VEC_NMI : vec;                   // [RQ6]
        end else if (do_return) begin
            pc_load  <= 1'b1;
            pc_value <= pc_stack[0];                                        // [RQ7]
        end else begin
            pc_load  <= 1'b0;
        end
    end

    // Releases the source's first latch so a second stored edge can follow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_clr <= 5'h00;
        end else if (do_entry && arb_bus.take_nmi) begin
            latch_clr <= 5'h01;                                             // [RQ5]
        end else if (do_entry) begin
            latch_clr <= 5'(5'h02 << arb_bus.irq_sel);                      // [RQ5]
        end else begin
            latch_clr <= 5'h00;
        end
    end
endmodule
`default_nettype wire

// ==== common/iecl_pkg.sv ====
// Shared constants and types for interrupt entry and low-power control
package iecl_pkg;
    localparam logic [11:0] ADDR_INT_OPTION     = 12'h0c8;
    localparam logic [11:0] ADDR_STATUS         = 12'h0cc;
    localparam logic [7:0]  INT_OPTION_RESET    = 8'h00;
    localparam int          BIT_GEN             = 4;
    localparam int          BIT_ESB             = 5;
    localparam int          BIT_LES             = 6;
    localparam logic [11:0] VEC_NMI             = 12'hffc;
    localparam logic [11:0] VEC_1               = 12'hff6;
    localparam logic [11:0] VEC_2               = 12'hff4;
    localparam logic [11:0] VEC_3               = 12'hff2;
    localparam logic [11:0] VEC_4               = 12'hff0;
    localparam int          STAB_CYCLES_DEFAULT = 256;
    localparam int          STACK_DEPTH_DEFAULT = 4;

    typedef enum logic [1:0] {
        CTX_MAIN = 2'b00,
        CTX_IRQ  = 2'b01,
        CTX_NMI  = 2'b10
    } iecl_ctx_e;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_WAIT = 2'b01,
        ST_STOP = 2'b10,
        ST_STAB = 2'b11
    } iecl_state_e;
endpackage

// ==== common/iecl_if.sv ====
// Carrier between the sequencer and the request arbiter
`timescale 1ns/100ps
`default_nettype none
interface iecl_if;
    import iecl_pkg::*;
    logic [3:0] req;
    logic       nmi;
    logic       gen;
    iecl_ctx_e  ctx;
    logic       take_nmi;
    logic       take_irq;
    logic [1:0] irq_sel;
    logic       wake;
    logic       pending;

    modport arb (
        input  req,
        input  nmi,
        input  gen,
        input  ctx,
        output take_nmi,
        output take_irq,
        output irq_sel,
        output wake,
        output pending
    );
    modport seq (
        output req,
        output nmi,
        output gen,
        output ctx,
        input  take_nmi,
        input  take_irq,
        input  irq_sel,
        input  wake,
        input  pending
    );
endinterface
`default_nettype wire

// ==== core/iecl_arbiter.sv ====
// Fixed-priority request arbiter with wake and pending detection
`timescale 1ns/100ps
`default_nettype none
module iecl_arbiter
    import iecl_pkg::*;
(
    iecl_if.arb bus
);
    logic any_irq;

    assign any_irq = |bus.req;
    // Nonmaskable path ignores the global enable; only a nested one is held off
    assign bus.take_nmi = bus.nmi && (bus.ctx != CTX_NMI);                  // [RQ8] [RQ23]
    // Maskable requests only from main context, so maskable routines never nest
    assign bus.take_irq = bus.gen && any_irq && (bus.ctx == CTX_MAIN)
                          && !bus.take_nmi;                                 // [RQ4] [RQ8] [RQ23]
    // Lowest index wins
    assign bus.irq_sel  = bus.req[0] ? 2'd0 :
                          bus.req[1] ? 2'd1 :
                          bus.req[2] ? 2'd2 : 2'd3;                         // [RQ23]
    // With the enable low nothing wakes, not even the nonmaskable pin
    assign bus.wake     = bus.gen && (bus.nmi || any_irq);                  // [RQ20]
    assign bus.pending  = bus.gen && (bus.nmi || any_irq);                  // [RQ21]
endmodule
`default_nettype wire

// ==== tb/iecl_core_props.sv ====
// Checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module iecl_core_props
    import iecl_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_CYCLES_DEFAULT
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        instr_boundary,
    input wire logic        exec_stop,
    input wire logic        wdg_active,
    input wire logic        flag_c,
    input wire logic        flag_z,
    input wire logic        pc_load,
    input wire logic [11:0] pc_value,
    input wire logic [4:0]  latch_clr,
    input wire logic        core_halt,
    input wire logic        osc_stop,
    input wire logic [1:0]  service_ctx
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle");
    unmapped_err_a: assert property (psel && !penable && paddr != ADDR_INT_OPTION
        && paddr != ADDR_STATUS |=> pslverr) else $error("unmapped not refused");
    clr_pulse_a: assert property (latch_clr != 5'h0 |-> pc_load ##1 latch_clr == 5'h0)
        else $error("clear not load pulse");
    nmi_vector_a: assert property (latch_clr[0] |-> pc_value == VEC_NMI && !flag_c && !flag_z)
        else $error("nmi entry wrong");
    top_vector_a: assert property (latch_clr[1] |-> pc_value == VEC_1)
        else $error("vector one wrong");
    low_vector_a: assert property (latch_clr[4] |-> pc_value == VEC_4)
        else $error("vector four wrong");
    osc_halt_a: assert property (osc_stop |-> core_halt)
        else $error("osc stop while running");
    stop_wait_a: assert property (instr_boundary && exec_stop && wdg_active && !osc_stop
        |=> !osc_stop) else $error("stop not made wait");
    stab_hold_a: assert property ($fell(osc_stop) |-> core_halt[*3])
        else $error("no settling delay");
    irq_block_a: assert property (service_ctx == 2'b01 && $past(service_ctx) == 2'b01
        |-> latch_clr[4:1] == 4'h0) else $error("maskable nested");

    stop_wake_c: cover property ($fell(osc_stop));
    nmi_entry_c: cover property (latch_clr[0]);
    refused_c: cover property (pready && pslverr);
endmodule
bind iecl_core iecl_core_props #(.STAB_CYCLES(STAB_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .instr_boundary(instr_boundary),
    .exec_stop(exec_stop), .wdg_active(wdg_active), .flag_c(flag_c), .flag_z(flag_z),
    .pc_load(pc_load), .pc_value(pc_value), .latch_clr(latch_clr), .core_halt(core_halt),
    .osc_stop(osc_stop), .service_ctx(service_ctx));
`default_nettype wire

// ==== tb/iecl_src_model.sv ====
// Request latches for pins and peripherals
`timescale 1ns/100ps
`default_nettype none
module iecl_src_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] set_irq,
    input  wire logic       set_nmi,
    input  wire logic [4:0] latch_clr,
    output var  logic [3:0] irq_req,
    output var  logic       nmi_req
);
    // Set wins over clear so a fresh edge is never lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 4'h0;
            nmi_req <= 1'b0;
        end else begin
            irq_req <= (irq_req & ~latch_clr[4:1]) | set_irq;
            nmi_req <= (nmi_req & ~latch_clr[0]) | set_nmi;
        end
    end
endmodule
`default_nettype wire

// ==== tb/interrupt_entry_and_low_power_control_tb.sv ====
// Bench for the interrupt sequencer
`timescale 1ns/100ps
`default_nettype none
module interrupt_entry_and_low_power_control_tb;
    import iecl_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        instr_boundary, exec_wait, exec_stop, exec_return, flag_we, flag_c_in;
    logic        flag_z_in, wdg_active, set_nmi, nmi_req, flag_c, flag_z, pc_load;
    logic        core_halt, osc_stop, level_mode_a, rise_mode_bc;
    logic [11:0] paddr, pc_current, pc_value;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  set_irq, irq_req;
    logic [4:0]  latch_clr;
    logic [1:0]  service_ctx;
    int          err_total = 0, samples_checked = 0, cyc = 0, n;

    iecl_core #(.STAB_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_boundary(instr_boundary),
        .exec_wait(exec_wait), .exec_stop(exec_stop), .exec_return(exec_return),
        .pc_current(pc_current), .flag_we(flag_we), .flag_c_in(flag_c_in),
        .flag_z_in(flag_z_in), .wdg_active(wdg_active), .nmi_req(nmi_req), .irq_req(irq_req),
        .flag_c(flag_c), .flag_z(flag_z), .pc_load(pc_load), .pc_value(pc_value),
        .latch_clr(latch_clr), .core_halt(core_halt), .osc_stop(osc_stop),
        .service_ctx(service_ctx), .level_mode_a(level_mode_a), .rise_mode_bc(rise_mode_bc));
    iecl_src_model u_src (.pclk(pclk), .presetn(presetn), .set_irq(set_irq),
        .set_nmi(set_nmi), .latch_clr(latch_clr), .irq_req(irq_req), .nmi_req(nmi_req));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic bnd(input logic w, input logic s, input logic r, input logic [11:0] pc);
        @(posedge pclk);
        instr_boundary <= 1'b1;
        exec_wait      <= w;
        exec_stop      <= s;
        exec_return    <= r;
        pc_current     <= pc;
        @(posedge pclk);
        instr_boundary <= 1'b0;
        exec_wait      <= 1'b0;
        exec_stop      <= 1'b0;
        exec_return    <= 1'b0;
        #1;
    endtask

    task automatic raise(input logic [3:0] m, input logic nm);
        @(posedge pclk);
        set_irq <= m;
        set_nmi <= nm;
        @(posedge pclk);
        set_irq <= 4'h0;
        set_nmi <= 1'b0;
    endtask

    task automatic setf(input logic c, input logic z);
        @(posedge pclk);
        flag_we   <= 1'b1;
        flag_c_in <= c;
        flag_z_in <= z;
        @(posedge pclk);
        flag_we   <= 1'b0;
    endtask

    task automatic wake();
        n = 0;
        while (core_halt !== 1'b0 && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task automatic ent(input logic [11:0] v, input logic [4:0] c);
        chk("pc_load", 32'h1, 32'(pc_load));
        chk("pc_value", 32'(v), 32'(pc_value));
        chk("latch_clr", 32'(c), 32'(latch_clr));
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic t_regs();
        apb(1'b0, ADDR_INT_OPTION, 32'h0);
        chk("option_read", 32'h0, rd);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_reset", 32'h0, rd);
        apb(1'b0, 12'h0d0, 32'h0);
        chk("unmapped_err", 32'h1, 32'(er));
        apb(1'b1, ADDR_STATUS, 32'hff);
        chk("ro_err", 32'h1, 32'(er));
    endtask

    task automatic t_gate();
        raise(4'h1, 1'b0);
        bnd(1'b0, 1'b0, 1'b0, 12'h010);
        chk("gated_load", 32'h0, 32'(pc_load));
        bnd(1'b1, 1'b0, 1'b0, 12'h011);
        raise(4'h0, 1'b1);
        repeat (6) @(posedge pclk);
        #1;
        chk("no_wake", 32'h1, 32'(core_halt));
        do_reset();
        #1;
        chk("reset_wake", 32'h0, 32'(core_halt));
    endtask

    task automatic t_entry();
        apb(1'b1, ADDR_INT_OPTION, 32'h70);
        repeat (2) @(posedge pclk);
        #1;
        chk("edge_modes", 32'h3, 32'({level_mode_a, rise_mode_bc}));
        setf(1'b1, 1'b1);
        raise(4'ha, 1'b0);
        bnd(1'b0, 1'b0, 1'b0, 12'h123);
        ent(VEC_2, 5'b00100);
        chk("irq_flags", 32'h0, 32'({flag_c, flag_z}));
        @(posedge pclk);
        #1;
        chk("irq_ctx", 32'h1, 32'(service_ctx));
        bnd(1'b0, 1'b0, 1'b0, 12'h124);
        chk("masked_nest", 32'h0, 32'(pc_load));
        setf(1'b1, 1'b0);
        raise(4'h0, 1'b1);
        bnd(1'b0, 1'b0, 1'b0, 12'h200);
        ent(VEC_NMI, 5'b00001);
        bnd(1'b0, 1'b0, 1'b1, 12'h300);
        chk("nmi_ret_pc", 32'h200, 32'(pc_value));
        chk("irq_flags_back", 32'h2, 32'({flag_c, flag_z}));
        bnd(1'b0, 1'b0, 1'b1, 12'h201);
        chk("main_ret_pc", 32'h123, 32'(pc_value));
        chk("main_flags", 32'h3, 32'({flag_c, flag_z}));
        bnd(1'b0, 1'b0, 1'b0, 12'h124);
        ent(VEC_4, 5'b10000);
        bnd(1'b0, 1'b0, 1'b1, 12'h400);
    endtask

    task automatic t_sleep();
        bnd(1'b1, 1'b0, 1'b0, 12'h040);
        chk("wait_halt", 32'h2, 32'({core_halt, osc_stop}));
        raise(4'h1, 1'b0);
        wake();
        chk("wait_nodelay", 32'h1, 32'(n == 1));
        bnd(1'b0, 1'b0, 1'b0, 12'h041);
        ent(VEC_1, 5'b00010);
        bnd(1'b0, 1'b0, 1'b1, 12'h400);
        chk("resume_pc", 32'h041, 32'(pc_value));
        @(posedge pclk);
        wdg_active <= 1'b1;
        bnd(1'b0, 1'b1, 1'b0, 12'h050);
        chk("stop_as_wait", 32'h2, 32'({core_halt, osc_stop}));
        raise(4'h8, 1'b0);
        wake();
        bnd(1'b0, 1'b0, 1'b0, 12'h051);
        ent(VEC_4, 5'b10000);
        bnd(1'b0, 1'b0, 1'b1, 12'h400);
        @(posedge pclk);
        wdg_active <= 1'b0;
        bnd(1'b0, 1'b1, 1'b0, 12'h060);
        chk("stop_osc", 32'h3, 32'({core_halt, osc_stop}));
        raise(4'h2, 1'b0);
        wake();
        chk("stop_stab", 32'h1, 32'(n >= 5));
        bnd(1'b0, 1'b0, 1'b0, 12'h061);
        ent(VEC_2, 5'b00100);
        bnd(1'b0, 1'b0, 1'b1, 12'h400);
    endtask

    task automatic t_refuse();
        raise(4'h4, 1'b0);
        bnd(1'b1, 1'b0, 1'b0, 12'h070);
        chk("sleep_refused", 32'h0, 32'({core_halt, pc_load}));
        bnd(1'b0, 1'b0, 1'b0, 12'h070);
        ent(VEC_3, 5'b01000);
        bnd(1'b0, 1'b0, 1'b1, 12'h400);
        raise(4'h0, 1'b1);
        bnd(1'b0, 1'b0, 1'b0, 12'h080);
        bnd(1'b1, 1'b0, 1'b0, 12'h081);
        raise(4'h1, 1'b0);
        wake();
        bnd(1'b0, 1'b0, 1'b0, 12'h082);
        chk("nmi_ctx_stay", 32'h0, 32'(pc_load));
    endtask

    initial begin
        {presetn, psel, penable, pwrite, instr_boundary, exec_wait, exec_stop} = 7'h0;
        {exec_return, flag_we, flag_c_in, flag_z_in, wdg_active, set_nmi} = 6'h0;
        {paddr, pwdata, pc_current, set_irq} = 60'h0;
        do_reset();
        t_regs();
        t_gate();
        t_entry();
        t_sleep();
        t_refuse();
        give_verdict();
    end
endmodule
`default_nettype wire
